// File: pcod_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module pcod_decoder (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic byteValid,
   input wire logic [7:0] byteData,
   output logic byteReady,
   input wire logic wordOp,
   input wire logic rangeViolation,
   input wire logic stringDest,
   input wire logic coprocIdlePin,
   input wire logic wakeReq,
   input wire logic [15:0] baseReg,
   input wire logic [15:0] framePtr,
   input wire logic [15:0] sourceIdx,
   input wire logic [15:0] targetIdx,
   output logic carryFlag,
   output logic directionFlag,
   output logic interruptEnable,
   output logic halted,
   output logic busLock,
   output logic instrDone,
   output logic illegalOp,
   output logic [7:0] cycleCost,
   output logic locValid,
   output logic [15:0] operandLocation,
   output logic [1:0] operandSegment,
   output logic operandIsReg,
   output logic [3:0] regSlot,
   output logic [3:0] memSlot
);
   pcod_pkg::pcod_state_t state;
   logic [7:0] remaining;
   logic [7:0] opcode;
   logic [1:0] formField;
   logic [2:0] slotField;
   logic [2:0] memField;
   logic [7:0] ofsLo;
   logic [7:0] ofsHi;
   logic ovrValid;
   logic [1:0] ovrSel;
   logic isPrefix;
   logic idleMeta;
   logic idleSync;
   logic [2:0] locCount;
   logic opTake;
   logic segPrefix;
   logic known;
   logic [7:0] opCost;
   logic locStart;
   logic [7:0] rangeCost;
   logic [15:0] calcLoc;
   logic [1:0] calcSeg;
   logic calcIsReg;
   logic [3:0] calcSlot;
   logic [3:0] calcMemSlot;
   logic [1:0] lastForm;

   // ==========================================================
   // Handshake and opcode classification
   assign byteReady = !halted && (state == pcod_pkg::ST_OPCODE || state == pcod_pkg::ST_FORM
                      || state == pcod_pkg::ST_OFS_LO || state == pcod_pkg::ST_OFS_HI);
   assign opTake = byteValid && byteReady && state == pcod_pkg::ST_OPCODE;
   assign segPrefix = (byteData & pcod_pkg::SEG_PREFIX_MASK) == pcod_pkg::SEG_PREFIX_VAL;
   assign instrDone = state == pcod_pkg::ST_EXEC && remaining == 8'h01;
   assign illegalOp = opTake && !known;
   // The form register loads on the same edge as the addressing byte, so use the byte itself
   assign lastForm = (state == pcod_pkg::ST_FORM) ? byteData[7:6] : formField;

   always_comb begin
      known = 1'b1;
      opCost = pcod_pkg::CYC_CONTROL; // see RQ4 RQ5 RQ6
      unique case (byteData)
         pcod_pkg::OP_INT_RETURN: opCost = pcod_pkg::CYC_INT_RETURN; // see RQ1
         pcod_pkg::OP_NO_OP: opCost = pcod_pkg::CYC_NO_OP; // see RQ6
         pcod_pkg::OP_COP_SYNC: opCost = pcod_pkg::CYC_COP_SYNC; // see RQ7
         pcod_pkg::OP_CLEAR_CARRY, pcod_pkg::OP_INVERT_CARRY, pcod_pkg::OP_SET_CARRY,
         pcod_pkg::OP_CLEAR_DIR, pcod_pkg::OP_SET_DIR, pcod_pkg::OP_INT_DISABLE,
         pcod_pkg::OP_INT_ENABLE, pcod_pkg::OP_HALT, pcod_pkg::OP_BUS_HOLD,
         pcod_pkg::OP_RANGE_CHECK: opCost = pcod_pkg::CYC_CONTROL;
         default: begin
            opCost = pcod_pkg::CYC_SEG_PREFIX;
            known = segPrefix;
         end
      endcase
   end

   // Last operand byte of range_check: addressing byte or final offset byte
   always_comb begin
      locStart = 1'b0;
      if (byteValid && byteReady) begin
         unique case (state)
            pcod_pkg::ST_FORM: locStart = byteData[7:6] == pcod_pkg::FORM_REG
               || (byteData[7:6] == pcod_pkg::FORM_NO_OFS
               && byteData[2:0] != pcod_pkg::FIELD_DIRECT);
            pcod_pkg::ST_OFS_LO: locStart = formField == pcod_pkg::FORM_OFS8;
            pcod_pkg::ST_OFS_HI: locStart = 1'b1;
            default: locStart = 1'b0;
         endcase
      end
   end

   // Two bound reads from memory cost extra for word operations
   always_comb begin
      rangeCost = rangeViolation ? pcod_pkg::CYC_RANGE_OUT : pcod_pkg::CYC_RANGE_IN; // see RQ2
      if (wordOp && lastForm != pcod_pkg::FORM_REG) begin
         rangeCost = rangeCost + pcod_pkg::CYC_WORD_XFER * pcod_pkg::RANGE_XFERS; // see RQ3
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= pcod_pkg::ST_OPCODE;
         remaining <= 8'h00;
         cycleCost <= 8'h00;
         opcode <= 8'h00;
         isPrefix <= 1'b0;
      end else begin
         unique case (state)
            pcod_pkg::ST_OPCODE: begin
               if (opTake && known) begin
                  opcode <= byteData;
                  isPrefix <= segPrefix || byteData == pcod_pkg::OP_BUS_HOLD;
                  cycleCost <= opCost;
                  remaining <= opCost;
                  if (byteData == pcod_pkg::OP_RANGE_CHECK) begin
                     state <= pcod_pkg::ST_FORM; // see RQ2
                  end else if (byteData == pcod_pkg::OP_COP_SYNC && idleSync) begin
                     state <= pcod_pkg::ST_COP_WAIT; // see RQ7
                  end else begin
                     state <= pcod_pkg::ST_EXEC;
                  end
               end
            end
            pcod_pkg::ST_FORM: begin
               if (byteValid) begin
                  if (byteData[7:6] == pcod_pkg::FORM_OFS8
                      || byteData[7:6] == pcod_pkg::FORM_OFS16
                      || byteData[2:0] == pcod_pkg::FIELD_DIRECT
                      && byteData[7:6] == pcod_pkg::FORM_NO_OFS) begin
                     state <= pcod_pkg::ST_OFS_LO; // see RQ13
                  end
               end
            end
            pcod_pkg::ST_OFS_LO: begin
               if (byteValid && formField != pcod_pkg::FORM_OFS8) begin
                  state <= pcod_pkg::ST_OFS_HI; // see RQ9
               end
            end
            pcod_pkg::ST_OFS_HI: ;
            pcod_pkg::ST_COP_WAIT: begin
               // Stall while the coprocessor still reports busy
               if (!idleSync) begin
                  state <= pcod_pkg::ST_EXEC; // see RQ7
               end
            end
            pcod_pkg::ST_EXEC: begin
               remaining <= remaining - 8'h01;
               if (instrDone) begin
                  state <= pcod_pkg::ST_OPCODE;
               end
            end
            default: state <= pcod_pkg::ST_OPCODE;
         endcase
         // Operand collection ends by entering execution with the full cost
         if (locStart) begin
            state <= pcod_pkg::ST_EXEC;
            remaining <= rangeCost;
            cycleCost <= rangeCost; // see RQ2 RQ3
         end
      end
   end

   // ==========================================================
   // Addressing byte and offset capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         formField <= pcod_pkg::FORM_NO_OFS;
         slotField <= 3'h0;
         memField <= 3'h0;
         ofsLo <= 8'h00;
         ofsHi <= 8'h00;
      end else if (byteValid && byteReady) begin
         if (state == pcod_pkg::ST_FORM) begin
            formField <= byteData[7:6];
            slotField <= byteData[5:3];
            memField <= byteData[2:0];
            ofsLo <= 8'h00;
            ofsHi <= 8'h00;
         end else if (state == pcod_pkg::ST_OFS_LO) begin
            ofsLo <= byteData; // see RQ13
         end else if (state == pcod_pkg::ST_OFS_HI) begin
            ofsHi <= byteData;
         end
      end
   end

   // ==========================================================
   // Flag operations take effect as the opcode is accepted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carryFlag <= pcod_pkg::CARRY_RST;
         directionFlag <= pcod_pkg::DIR_RST;
         interruptEnable <= pcod_pkg::INT_EN_RST;
      end else if (opTake) begin
         unique case (byteData)
            pcod_pkg::OP_CLEAR_CARRY: carryFlag <= 1'b0; // see RQ4
            pcod_pkg::OP_INVERT_CARRY: carryFlag <= !carryFlag; // see RQ4
            pcod_pkg::OP_SET_CARRY: carryFlag <= 1'b1; // see RQ4
            pcod_pkg::OP_CLEAR_DIR: directionFlag <= 1'b0; // see RQ5
            pcod_pkg::OP_SET_DIR: directionFlag <= 1'b1; // see RQ5
            pcod_pkg::OP_INT_DISABLE: interruptEnable <= 1'b0; // see RQ5
            pcod_pkg::OP_INT_ENABLE: interruptEnable <= 1'b1; // see RQ5
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Prefix state lasts until the next non-prefix instruction ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busLock <= 1'b0;
         ovrValid <= 1'b0;
         ovrSel <= pcod_pkg::SEG_DATA;
         halted <= 1'b0;
      end else begin
         if (instrDone && !isPrefix) begin
            busLock <= 1'b0;
            ovrValid <= 1'b0;
         end
         if (opTake && byteData == pcod_pkg::OP_BUS_HOLD) begin
            busLock <= 1'b1; // see RQ6
         end
         if (opTake && segPrefix) begin
            ovrValid <= 1'b1; // see RQ15
            ovrSel <= byteData[pcod_pkg::SEG_SEL_LSB +: 2];
         end
         // Halt holds off new opcodes until a wake request
         if (instrDone && opcode == pcod_pkg::OP_HALT) begin
            halted <= 1'b1; // see RQ6
         end else if (wakeReq) begin
            halted <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Coprocessor idle pin crosses in through two flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idleMeta <= 1'b1;
         idleSync <= 1'b1;
      end else begin
         idleMeta <= coprocIdlePin;
         idleSync <= idleMeta;
      end
   end

   // ==========================================================
   // Operand location settles four cycles after the last operand byte
   pcod_loc_calc u_loc (
      .addrForm(formField),
      .memField(memField),
      .slotField(slotField),
      .ofsLo(ofsLo),
      .ofsHi(ofsHi),
      .wordOp(wordOp),
      .ovrValid(ovrValid),
      .ovrSel(ovrSel),
      .stringDest(stringDest),
      .baseReg(baseReg),
      .framePtr(framePtr),
      .sourceIdx(sourceIdx),
      .targetIdx(targetIdx),
      .location(calcLoc),
      .segment(calcSeg),
      .isReg(calcIsReg),
      .slotSel(calcSlot),
      .memSlotSel(calcMemSlot)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         locCount <= 3'h0;
         locValid <= 1'b0;
         operandLocation <= 16'h0000;
         operandSegment <= pcod_pkg::SEG_DATA;
         operandIsReg <= 1'b0;
         regSlot <= 4'h0;
         memSlot <= 4'h0;
      end else begin
         if (locStart) begin
            locCount <= 3'h1;
         end else if (locCount != 3'h0 && locCount != pcod_pkg::CYC_LOCATION) begin
            locCount <= locCount + 3'h1;
         end else begin
            locCount <= 3'h0;
         end
         // Load on the third count so the result shows on the fourth
         if (locCount == pcod_pkg::CYC_LOCATION - 3'h1) begin
            locValid <= 1'b1; // see RQ14
            operandLocation <= calcLoc;
            operandSegment <= calcSeg;
            operandIsReg <= calcIsReg;
            regSlot <= calcSlot;
            memSlot <= calcMemSlot;
         end else if (instrDone) begin
            locValid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_RETURN_COST: assert property (opTake && byteData == pcod_pkg::OP_INT_RETURN // see RQ1
      |-> ##1 !instrDone [*8] ##20 instrDone) else $error("return cost not 28");
   AST_RANGE_COST: assert property (locStart && opcode == pcod_pkg::OP_RANGE_CHECK // see RQ2
      |=> cycleCost == $past(rangeCost) && remaining == cycleCost
      && (cycleCost == 8'h21 || cycleCost == 8'h23 || cycleCost == 8'h29 || cycleCost == 8'h2b))
      else $error("range cost wrong");
   AST_WORD_EXTRA: assert property (locStart && wordOp && lastForm != pcod_pkg::FORM_REG // see RQ3
      |=> cycleCost >= 8'h29) else $error("word transfers not charged");
   AST_CARRY_INV: assert property (opTake && byteData == pcod_pkg::OP_INVERT_CARRY // see RQ4
      |=> carryFlag != $past(carryFlag) ##1 instrDone) else $error("invert carry wrong");
   AST_CARRY_CLR: assert property (opTake && byteData == pcod_pkg::OP_CLEAR_CARRY // see RQ4
      |=> !carryFlag ##1 instrDone) else $error("clear carry wrong");
   AST_DIR_INT: assert property (opTake && byteData == pcod_pkg::OP_INT_ENABLE // see RQ5
      |=> interruptEnable && directionFlag == $past(directionFlag) ##1 instrDone)
      else $error("enable interrupts wrong");
   AST_HALT: assert property (opTake && byteData == pcod_pkg::OP_HALT // see RQ6
      |-> ##2 instrDone ##1 halted && !byteReady) else $error("halt wrong");
   AST_NO_OP: assert property (opTake && byteData == pcod_pkg::OP_NO_OP // see RQ6
      |-> ##1 !instrDone [*2] ##1 instrDone) else $error("no_operation cost wrong");
   AST_COP_SYNC: assert property (opTake && byteData == pcod_pkg::OP_COP_SYNC && !idleSync // see RQ7
      |-> ##6 instrDone) else $error("sync cost wrong");
   AST_LOC_TIME: assert property (locStart // see RQ14
      |-> ##1 !locValid [*3] ##1 locValid) else $error("location not at 4 cycles");
   AST_REG_FORM: assert property ($rose(locValid) // see RQ8
      |-> operandIsReg == (formField == pcod_pkg::FORM_REG)) else $error("register form wrong");
   AST_DIRECT: assert property (locCount == 3'h3 && !stringDest && memField == 3'h6 // see RQ12
      && formField == pcod_pkg::FORM_NO_OFS |=> operandLocation == {ofsHi, ofsLo})
      else $error("direct location wrong");
   AST_STACK_SEG: assert property (locCount == 3'h3 && !stringDest && !ovrValid // see RQ17
      && formField != pcod_pkg::FORM_REG && memField[2:1] == 2'h1
      |=> operandSegment == pcod_pkg::SEG_STACK) else $error("frame segment wrong");
   AST_STRING_SEG: assert property (locCount == 3'h3 && stringDest // see RQ18
      |=> operandSegment == pcod_pkg::SEG_EXTRA) else $error("string segment wrong");

   COV_RETURN: cover property (opTake && byteData == pcod_pkg::OP_INT_RETURN ##28 instrDone);
   COV_RANGE: cover property (locStart ##4 locValid && ovrValid);
   COV_COP_STALL: cover property (state == pcod_pkg::ST_COP_WAIT [*3] ##1 !idleSync);
endmodule : pcod_decoder
`default_nettype wire

// File: pcod_pkg.sv
// Overview of operation
// (RQ1) Opcode cf is interrupt_return, always 28 cycles.
// (RQ2) Opcode 62 plus addressing byte is range_check, 33 to 35 cycles.
// (RQ3) Word operations add 4 cycles per memory transfer.
// (RQ4) Opcodes f8, f5, f9 clear, invert, set carry; 2 cycles each.
// (RQ5) fc, fd clear/set direction; fa, fb disable/enable interrupts; 2 cycles.
// (RQ6) f0 is bus hold prefix, f4 halt, 2 cycles; 90 no_operation, 3.
// (RQ7) 9b is coprocessor_sync, 6 cycles once the idle input reads low.
// (RQ8) Addressing form 11 makes the memory operand field a register selector.
// (RQ9) Form 00 no offset, 01 sign-extended byte, 10 high:low word.
// (RQ10) Codes 000-011: base_reg/frame_pointer plus source/target index plus offset.
// (RQ11) Codes 100-111: source, target, frame_pointer, base_reg plus offset.
// (RQ12) Form 00 with code 110 uses a direct 16-bit offset only.
// (RQ13) Offset bytes follow the second byte, ahead of immediate data.
// (RQ14) Operand location takes 4 cycles, inside the instruction cost.
// (RQ15) Prefix 001ss110 overrides segment: extra, code, stack, data.
// (RQ16) Slot codes pick word registers; byte ops pick low then high halves.
// (RQ17) Frame_pointer operands default to the stack segment.
// (RQ18) String destinations via target_index always use extra segment.
package pcod_pkg;
   // ==========================================================
   // Opcodes
   localparam logic [7:0] OP_INT_RETURN = 8'hcf;
   localparam logic [7:0] OP_RANGE_CHECK = 8'h62;
   localparam logic [7:0] OP_CLEAR_CARRY = 8'hf8;
   localparam logic [7:0] OP_INVERT_CARRY = 8'hf5;
   localparam logic [7:0] OP_SET_CARRY = 8'hf9;
   localparam logic [7:0] OP_CLEAR_DIR = 8'hfc;
   localparam logic [7:0] OP_SET_DIR = 8'hfd;
   localparam logic [7:0] OP_INT_DISABLE = 8'hfa;
   localparam logic [7:0] OP_INT_ENABLE = 8'hfb;
   localparam logic [7:0] OP_HALT = 8'hf4;
   localparam logic [7:0] OP_COP_SYNC = 8'h9b;
   localparam logic [7:0] OP_BUS_HOLD = 8'hf0;
   localparam logic [7:0] OP_NO_OP = 8'h90;
   localparam logic [7:0] SEG_PREFIX_MASK = 8'he7;
   localparam logic [7:0] SEG_PREFIX_VAL = 8'h26;
   localparam int SEG_SEL_LSB = 3;
   // ==========================================================
   // Cycle costs
   localparam logic [7:0] CYC_INT_RETURN = 8'h1c;
   localparam logic [7:0] CYC_RANGE_IN = 8'h21;
   localparam logic [7:0] CYC_RANGE_OUT = 8'h23;
   localparam logic [7:0] CYC_WORD_XFER = 8'h04;
   localparam logic [7:0] RANGE_XFERS = 8'h02;
   localparam logic [7:0] CYC_CONTROL = 8'h02;
   localparam logic [7:0] CYC_NO_OP = 8'h03;
   localparam logic [7:0] CYC_COP_SYNC = 8'h06;
   localparam logic [7:0] CYC_SEG_PREFIX = 8'h02;
   localparam logic [2:0] CYC_LOCATION = 3'h4;
   // ==========================================================
   // Addressing fields and segments
   localparam logic [1:0] FORM_NO_OFS = 2'h0;
   localparam logic [1:0] FORM_OFS8 = 2'h1;
   localparam logic [1:0] FORM_OFS16 = 2'h2;
   localparam logic [1:0] FORM_REG = 2'h3;
   localparam logic [2:0] FIELD_DIRECT = 3'h6;
   localparam logic [1:0] SEG_EXTRA = 2'h0;
   localparam logic [1:0] SEG_CODE = 2'h1;
   localparam logic [1:0] SEG_STACK = 2'h2;
   localparam logic [1:0] SEG_DATA = 2'h3;
   // ==========================================================
   // Reset values
   localparam logic CARRY_RST = 1'b0;
   localparam logic DIR_RST = 1'b0;
   localparam logic INT_EN_RST = 1'b0;
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_FORM = 3'b001,
      ST_OFS_LO = 3'b010,
      ST_OFS_HI = 3'b011,
      ST_EXEC = 3'b100,
      ST_COP_WAIT = 3'b101
   } pcod_state_t;
endpackage : pcod_pkg

// File: pcod_loc_calc.sv
`timescale 1ns/1ps
`default_nettype none
module pcod_loc_calc (
   input wire logic [1:0] addrForm,
   input wire logic [2:0] memField,
   input wire logic [2:0] slotField,
   input wire logic [7:0] ofsLo,
   input wire logic [7:0] ofsHi,
   input wire logic wordOp,
   input wire logic ovrValid,
   input wire logic [1:0] ovrSel,
   input wire logic stringDest,
   input wire logic [15:0] baseReg,
   input wire logic [15:0] framePtr,
   input wire logic [15:0] sourceIdx,
   input wire logic [15:0] targetIdx,
   output logic [15:0] location,
   output logic [1:0] segment,
   output logic isReg,
   output logic [3:0] slotSel,
   output logic [3:0] memSlotSel
);
   logic [15:0] ofs;
   logic stackBased;

   // ==========================================================
   // Offset and register combination
   always_comb begin
      isReg = (addrForm == pcod_pkg::FORM_REG); // see RQ8
      unique case (addrForm) // see RQ9
         pcod_pkg::FORM_OFS8: ofs = {{8{ofsLo[7]}}, ofsLo};
         pcod_pkg::FORM_OFS16: ofs = {ofsHi, ofsLo};
         default: ofs = 16'h0000;
      endcase
      stackBased = 1'b0;
      unique case (memField) // see RQ10 RQ11
         3'h0: location = baseReg + sourceIdx + ofs;
         3'h1: location = baseReg + targetIdx + ofs;
         3'h2: begin
            location = framePtr + sourceIdx + ofs;
            stackBased = 1'b1;
         end
         3'h3: begin
            location = framePtr + targetIdx + ofs;
            stackBased = 1'b1;
         end
         3'h4: location = sourceIdx + ofs;
         3'h5: location = targetIdx + ofs;
         3'h6: begin
            location = framePtr + ofs;
            stackBased = 1'b1;
         end
         3'h7: location = baseReg + ofs;
      endcase
      // Direct form has no register, so it is not stack based either
      if (addrForm == pcod_pkg::FORM_NO_OFS && memField == pcod_pkg::FIELD_DIRECT) begin
         location = {ofsHi, ofsLo}; // see RQ12
         stackBased = 1'b0;
      end
      // Override beats the default, but never a string destination
      segment = stackBased ? pcod_pkg::SEG_STACK : pcod_pkg::SEG_DATA; // see RQ17
      if (ovrValid) begin
         segment = ovrSel; // see RQ15
      end
      if (stringDest) begin
         location = targetIdx;
         segment = pcod_pkg::SEG_EXTRA; // see RQ18
      end
   end

   // ==========================================================
   // Slot decode: bit 3 marks a high byte half
   always_comb begin
      slotSel = wordOp ? {1'b0, slotField} : {slotField[2], 1'b0, slotField[1:0]}; // see RQ16
      memSlotSel = wordOp ? {1'b0, memField} : {memField[2], 1'b0, memField[1:0]}; // see RQ16
   end
endmodule : pcod_loc_calc
`default_nettype wire

// File: test_processor_control_and_operand_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_processor_control_and_operand_decode;
   // ==========================================================
   // Stimulus and observed signals
   logic clk, rst_n, byteValid, byteReady, wordOp, rangeViolation, stringDest;
   logic coprocIdlePin, wakeReq, carryFlag, directionFlag, interruptEnable, halted;
   logic busLock, instrDone, illegalOp, locValid, operandIsReg;
   logic [7:0] byteData, cycleCost;
   logic [15:0] baseReg, framePtr, sourceIdx, targetIdx, operandLocation;
   logic [1:0] operandSegment;
   logic [3:0] regSlot, memSlot;
   int miscompares, checks_done;
   pcod_decoder dut (.clk(clk), .rst_n(rst_n), .byteValid(byteValid), .byteData(byteData),
      .byteReady(byteReady), .wordOp(wordOp), .rangeViolation(rangeViolation),
      .stringDest(stringDest), .coprocIdlePin(coprocIdlePin), .wakeReq(wakeReq),
      .baseReg(baseReg), .framePtr(framePtr), .sourceIdx(sourceIdx), .targetIdx(targetIdx),
      .carryFlag(carryFlag), .directionFlag(directionFlag), .interruptEnable(interruptEnable),
      .halted(halted), .busLock(busLock), .instrDone(instrDone), .illegalOp(illegalOp),
      .cycleCost(cycleCost), .locValid(locValid), .operandLocation(operandLocation),
      .operandSegment(operandSegment), .operandIsReg(operandIsReg), .regSlot(regSlot),
      .memSlot(memSlot));
   // 200 MHz core clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ==========================================================
   // Shared tasks
   task automatic complete_run;
      if (miscompares == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Valid stays high on return so a following byte needs no second edge on it
   task automatic put(input logic [7:0] b);
      int n;
      byteValid = 1'b1;
      byteData = b;
      n = 0;
      while (byteReady !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      @(negedge clk);
   endtask : put
   // Counts edges from the taking edge to the done pulse; pre skips edges already waited
   task automatic wait_done(input logic [7:0] cost, input int pre = 0);
      int n;
      byteValid = 1'b0;
      n = 1 + pre;
      while (instrDone !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk(16'(n), {8'h00, cost});
      chk({8'h00, cycleCost}, {8'h00, cost});
      rangeViolation = 1'b0;
      @(negedge clk);
   endtask : wait_done
   // ==========================================================
   // Scenarios
   task automatic t_flags;
      logic [7:0] ops [8] = '{8'hf9, 8'hf5, 8'hf5, 8'hf8, 8'hfd, 8'hfc, 8'hfb, 8'hfa};
      logic [2:0] fl [8] = '{3'h4, 3'h0, 3'h4, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0};
      for (int i = 0; i < 8; i++) begin
         put(ops[i]);
         wait_done(pcod_pkg::CYC_CONTROL);
         chk({13'h0, carryFlag, directionFlag, interruptEnable}, {13'h0, fl[i]});
      end
   endtask : t_flags
   task automatic t_misc;
      put(pcod_pkg::OP_NO_OP);
      wait_done(pcod_pkg::CYC_NO_OP);
      put(pcod_pkg::OP_INT_RETURN);
      wait_done(pcod_pkg::CYC_INT_RETURN);
      put(pcod_pkg::OP_BUS_HOLD);
      wait_done(pcod_pkg::CYC_CONTROL);
      chk({15'h0, busLock}, 16'h0001);
      put(pcod_pkg::OP_COP_SYNC);
      wait_done(pcod_pkg::CYC_COP_SYNC);
      chk({15'h0, busLock}, 16'h0000);
      // Busy coprocessor stalls sync; two sync flops and the exit edge add 3 cycles
      coprocIdlePin = 1'b1;
      repeat (2) @(negedge clk);
      put(pcod_pkg::OP_COP_SYNC);
      byteValid = 1'b0;
      coprocIdlePin = 1'b0;
      chk({15'h0, byteReady}, 16'h0000);
      wait_done(pcod_pkg::CYC_COP_SYNC, -3);
      byteValid = 1'b1;
      byteData = 8'h00;
      #1;
      chk({15'h0, illegalOp}, 16'h0001);
      @(posedge clk);
      @(negedge clk);
      byteValid = 1'b0;
      @(negedge clk);
   endtask : t_misc
   // Halt blocks further bytes until a wake request
   task automatic t_halt;
      put(pcod_pkg::OP_HALT);
      wait_done(pcod_pkg::CYC_CONTROL);
      chk({14'h0, halted, byteReady}, 16'h0002);
      wakeReq = 1'b1;
      @(negedge clk);
      wakeReq = 1'b0;
      @(negedge clk);
      chk({15'h0, halted}, 16'h0000);
   endtask : t_halt
   // Bounds check with one addressing form; expLoc holds the slot for register forms
   task automatic t_loc(input logic [7:0] pre, input logic [1:0] form, input logic [2:0] rm,
      input logic [15:0] ofs, input logic viol, input logic word, input logic sd,
      input logic [15:0] expLoc, input logic [1:0] expSeg, input logic [7:0] cost);
      if (pre != 8'h00) begin
         put(pre);
         wait_done(pcod_pkg::CYC_SEG_PREFIX);
      end
      wordOp = word;
      stringDest = sd;
      put(pcod_pkg::OP_RANGE_CHECK);
      if (form == 2'h1) begin
         put({form, 3'h6, rm});
         rangeViolation = viol;
         put(ofs[7:0]);
      end else if (form == 2'h2 || (form == 2'h0 && rm == 3'h6)) begin
         put({form, 3'h6, rm});
         put(ofs[7:0]);
         rangeViolation = viol;
         put(ofs[15:8]);
      end else begin
         rangeViolation = viol;
         put({form, 3'h6, rm});
      end
      // Location results are valid only until the instruction ends, so look before that
      byteValid = 1'b0;
      repeat (2) @(negedge clk);
      chk({15'h0, locValid}, 16'h0000);
      @(negedge clk);
      chk({15'h0, locValid}, 16'h0001);
      if (form == 2'h3) begin
         chk({11'h0, operandIsReg, memSlot}, {11'h0, 1'b1, expLoc[3:0]});
         chk({12'h0, regSlot}, {12'h0, word ? 4'h6 : 4'ha});
      end else begin
         if (sd == 1'b0) chk(operandLocation, expLoc);
         chk({14'h0, operandSegment}, {14'h0, expSeg});
      end
      wait_done(cost, 3);
      wordOp = 1'b0;
      stringDest = 1'b0;
   endtask : t_loc
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      {rst_n, byteValid, wordOp, rangeViolation, stringDest, wakeReq, coprocIdlePin} = '0;
      byteData = 8'h00;
      baseReg = 16'h1000;
      framePtr = 16'h2000;
      sourceIdx = 16'h0300;
      targetIdx = 16'h0040;
      miscompares = 0;
      checks_done = 0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      chk({13'h0, carryFlag, directionFlag, interruptEnable}, 16'h0000);
      t_flags();
      t_misc();
      t_halt();
      t_loc(8'h00, 2'h1, 3'h0, 16'h00f0, 1'b0, 1'b0, 1'b0, 16'h12f0, 2'h3, 8'h21);
      t_loc(8'h00, 2'h2, 3'h3, 16'h1234, 1'b1, 1'b0, 1'b0, 16'h3274, 2'h2, 8'h23);
      t_loc(8'h00, 2'h0, 3'h6, 16'h5678, 1'b0, 1'b1, 1'b0, 16'h5678, 2'h3, 8'h29);
      t_loc(8'h3e, 2'h1, 3'h2, 16'h007f, 1'b0, 1'b0, 1'b0, 16'h237f, 2'h3, 8'h21);
      t_loc(8'h2e, 2'h0, 3'h7, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h1000, 2'h1, 8'h21);
      t_loc(8'h3e, 2'h1, 3'h5, 16'h0002, 1'b0, 1'b0, 1'b1, 16'h0000, 2'h0, 8'h21);
      t_loc(8'h00, 2'h3, 3'h5, 16'h0009, 1'b0, 1'b0, 1'b0, 16'h0009, 2'h0, 8'h21);
      t_loc(8'h00, 2'h3, 3'h5, 16'h0005, 1'b0, 1'b1, 1'b0, 16'h0005, 2'h0, 8'h21);
      complete_run();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      complete_run();
   end
endmodule : test_processor_control_and_operand_decode
`default_nettype wire
